// ---- hdl/edbhf_top.sv ----
// How it works
// R1: tx base bits 31:2 RW, 1:0 read zero
// R2: rx base bits 31:2 RW, 1:0 read zero
// R3: software writes bases 4-byte aligned
// R4: software avoids base writes while busy
// R5: completed packet writes last descriptor to base
// R6: tx base feeds tx, rx base rx
// R7: 64-bit hash table in two words
// R8: software edits hash only when filtering idle
// R9: all bits clear at power-on reset
// R10: transmit request starts tx, hardware clears
// R11: receive enable gates packet reception
// R12: 6-bit index picks hash bit, accept if one
`timescale 1ns/1ps
`default_nettype none
module edbhf_top
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit path
    input wire logic tx_done,
    input wire logic tx_pkt_ok,
    input wire logic [31:0] tx_last_desc,
    output logic transmit_request,
    output logic [31:0] tx_desc_base,
    // receive path
    input wire logic rx_pkt_ok,
    input wire logic [31:0] rx_last_desc,
    output logic receive_enable,
    output logic [31:0] rx_desc_base,
    // receive hash filter
    input wire logic rx_addr_valid,
    input wire logic [47:0] rx_dest_addr,
    output logic hash_filter_enable,
    output logic hash_accept_valid,
    output logic hash_accept
);
    logic [29:0] tx_base_r, tx_base_nxt;
    logic [29:0] rx_base_r, rx_base_nxt;
    logic txreq_r, txreq_nxt;
    logic receive_enable_r, receive_enable_nxt;
    logic hash_filter_enable_r, hash_filter_enable_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic pready_r, pready_nxt;
    logic lk_pend_r, lk_pend_nxt;
    logic lk_valid_r, lk_valid_nxt;
    logic [5:0] lk_index;
    logic lk_bit;
    logic [63:0] table_bits;
    logic wr_en, rd_en, wr_lo, wr_hi;
    logic hash_accept_r, hash_accept_nxt;

    // fold the 48-bit destination into a 6-bit index
    function automatic logic [5:0] hash_index(input logic [47:0] a);
        logic [5:0] h;
        h = 6'h00;
        for (int i = 0; i < 8; i++)
            h = h ^ a[i*6 +: 6];
        return h;
    endfunction : hash_index

    ////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, answer after the first access edge
    assign wr_en = psel && penable && pwrite && !pready_r;
    assign rd_en = psel && penable && !pwrite && !pready_r;
    assign wr_lo = wr_en && (paddr == edbhf_pkg::HASH_FILTER_LOW_OFS); // R7
    assign wr_hi = wr_en && (paddr == edbhf_pkg::HASH_FILTER_HIGH_OFS); // R7
    assign lk_index = hash_index(rx_dest_addr); // R12

    edbhf_hash_mem u_hash
    (
        .pclk(pclk),
        .presetn(presetn),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .wr_data(pwdata),
        .rd_index(lk_index),
        .rd_bit(lk_bit),
        .table_bits(table_bits)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file next state
    always_comb
    begin
        tx_base_nxt = tx_base_r;
        rx_base_nxt = rx_base_r;
        txreq_nxt = txreq_r;
        receive_enable_nxt = receive_enable_r;
        hash_filter_enable_nxt = hash_filter_enable_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        // pready pulses one cycle into access, then drops
        pready_nxt = psel && penable && !pready_r;
        // hardware write-back of last used descriptor
        if (tx_pkt_ok)
            tx_base_nxt = tx_last_desc[31:edbhf_pkg::DESC_BASE_LSB]; // R5 R6
        if (rx_pkt_ok)
            rx_base_nxt = rx_last_desc[31:edbhf_pkg::DESC_BASE_LSB]; // R5 R6
        if (tx_done)
            txreq_nxt = 1'b0; // R10
        // software write wins over hardware update on the same base
        if (wr_en)
        begin
            case (paddr)
                edbhf_pkg::TX_DESC_START_ADDR_OFS:
                    tx_base_nxt = pwdata[31:edbhf_pkg::DESC_BASE_LSB]; // R1
                edbhf_pkg::RX_DESC_START_ADDR_OFS:
                    rx_base_nxt = pwdata[31:edbhf_pkg::DESC_BASE_LSB]; // R2
                edbhf_pkg::HASH_FILTER_LOW_OFS,
                edbhf_pkg::HASH_FILTER_HIGH_OFS,
                edbhf_pkg::STATUS_OFS:
                    pslverr_nxt = 1'b0;
                edbhf_pkg::CONTROLLER_CONTROL_OFS:
                begin
                    // a set request still arriving with done keeps the bit
                    txreq_nxt = pwdata[edbhf_pkg::TRANSMIT_REQUEST_BIT]; // R10
                    receive_enable_nxt = pwdata[edbhf_pkg::RECEIVE_ENABLE_BIT]; // R11
                end
                edbhf_pkg::RECEIVE_FILTER_CONFIG_OFS:
                    hash_filter_enable_nxt = pwdata[edbhf_pkg::HASH_FILTER_ENABLE_BIT];
                default:
                    pslverr_nxt = 1'b1;
            endcase
        end
        if (rd_en)
        begin
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                edbhf_pkg::TX_DESC_START_ADDR_OFS:
                    prdata_nxt = {tx_base_r, edbhf_pkg::DESC_LOW_MASK}; // R1
                edbhf_pkg::RX_DESC_START_ADDR_OFS:
                    prdata_nxt = {rx_base_r, edbhf_pkg::DESC_LOW_MASK}; // R2
                edbhf_pkg::HASH_FILTER_LOW_OFS:
                    prdata_nxt = table_bits[31:0]; // R7
                edbhf_pkg::HASH_FILTER_HIGH_OFS:
                    prdata_nxt = table_bits[63:32]; // R7
                edbhf_pkg::CONTROLLER_CONTROL_OFS:
                begin
                    prdata_nxt[edbhf_pkg::TRANSMIT_REQUEST_BIT] = txreq_r;
                    prdata_nxt[edbhf_pkg::RECEIVE_ENABLE_BIT] = receive_enable_r;
                end
                edbhf_pkg::RECEIVE_FILTER_CONFIG_OFS:
                    prdata_nxt[edbhf_pkg::HASH_FILTER_ENABLE_BIT] = hash_filter_enable_r;
                edbhf_pkg::STATUS_OFS:
                    prdata_nxt = {30'h0, lk_valid_r, hash_accept_r};
                default:
                    pslverr_nxt = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hash lookup: one cycle in the table, one to present the verdict
    always_comb
    begin
        // frames arriving with receive disabled are never looked up
        lk_pend_nxt = rx_addr_valid && receive_enable_r; // R11
        lk_valid_nxt = lk_pend_r;
        hash_accept_nxt = hash_accept_r;
        if (lk_pend_r)
            hash_accept_nxt = hash_filter_enable_r && lk_bit; // R12
    end

    // all state clears at power-on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_base_r <= edbhf_pkg::DESC_START_RESET[31:2]; // R9
            rx_base_r <= edbhf_pkg::DESC_START_RESET[31:2]; // R9
            txreq_r <= 1'b0;
            receive_enable_r <= 1'b0;
            hash_filter_enable_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
            lk_pend_r <= 1'b0;
            lk_valid_r <= 1'b0;
            hash_accept_r <= 1'b0;
        end
        else
        begin
            tx_base_r <= tx_base_nxt;
            rx_base_r <= rx_base_nxt;
            txreq_r <= txreq_nxt;
            receive_enable_r <= receive_enable_nxt;
            hash_filter_enable_r <= hash_filter_enable_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            pready_r <= pready_nxt;
            lk_pend_r <= lk_pend_nxt;
            lk_valid_r <= lk_valid_nxt;
            hash_accept_r <= hash_accept_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign transmit_request = txreq_r; // R10
    assign receive_enable = receive_enable_r; // R11
    assign hash_filter_enable = hash_filter_enable_r;
    assign tx_desc_base = {tx_base_r, edbhf_pkg::DESC_LOW_MASK}; // R6
    assign rx_desc_base = {rx_base_r, edbhf_pkg::DESC_LOW_MASK}; // R6
    assign hash_accept_valid = lk_valid_r;
    assign hash_accept = hash_accept_r;
endmodule : edbhf_top
`default_nettype wire

// ---- hdl/edbhf_pkg.sv ----
`default_nettype none
package edbhf_pkg;
    // register byte offsets on the apb slave
    localparam logic [7:0] TX_DESC_START_ADDR_OFS = 8'h00;
    localparam logic [7:0] RX_DESC_START_ADDR_OFS = 8'h04;
    localparam logic [7:0] HASH_FILTER_LOW_OFS = 8'h08;
    localparam logic [7:0] HASH_FILTER_HIGH_OFS = 8'h0C;
    localparam logic [7:0] CONTROLLER_CONTROL_OFS = 8'h10;
    localparam logic [7:0] RECEIVE_FILTER_CONFIG_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // field positions
    localparam int TRANSMIT_REQUEST_BIT = 9;
    localparam int RECEIVE_ENABLE_BIT = 8;
    localparam int HASH_FILTER_ENABLE_BIT = 15;
    localparam int DESC_BASE_LSB = 2;
    // reset values
    localparam logic [31:0] DESC_START_RESET = 32'h0000_0000;
    localparam logic [31:0] HASH_RESET = 32'h0000_0000;
    localparam logic [1:0] DESC_LOW_MASK = 2'h0;
endpackage : edbhf_pkg
`default_nettype wire

// ---- hdl/edbhf_hash_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// 64-entry one-bit hash table, registered lookup output
module edbhf_hash_mem
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write side, one 32-bit half at a time
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [31:0] wr_data,
    // lookup side
    input wire logic [5:0] rd_index,
    output logic rd_bit,
    // full contents for readback
    output logic [63:0] table_bits
);
    logic [63:0] bits_r;
    logic [63:0] bits_nxt;
    logic rd_bit_r;
    logic rd_bit_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next table contents and registered lookup
    always_comb
    begin
        bits_nxt = bits_r;
        if (wr_lo)
            bits_nxt[31:0] = wr_data; // R7
        if (wr_hi)
            bits_nxt[63:32] = wr_data; // R7
        rd_bit_nxt = bits_r[rd_index];
    end

    // all bits clear at power-on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bits_r <= 64'h0000_0000_0000_0000; // R9
            rd_bit_r <= 1'b0;
        end
        else
        begin
            bits_r <= bits_nxt;
            rd_bit_r <= rd_bit_nxt;
        end
    end

    assign rd_bit = rd_bit_r;
    assign table_bits = bits_r;
endmodule : edbhf_hash_mem
`default_nettype wire

// ---- test/edbhf_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module edbhf_properties
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // dma side
    input wire logic tx_pkt_ok,
    input wire logic rx_pkt_ok,
    input wire logic tx_done,
    input wire logic [31:0] tx_last_desc,
    input wire logic [31:0] rx_last_desc,
    input wire logic transmit_request,
    input wire logic receive_enable,
    input wire logic [31:0] tx_desc_base,
    input wire logic [31:0] rx_desc_base,
    // hash lookup
    input wire logic rx_addr_valid,
    input wire logic hash_filter_enable,
    input wire logic hash_accept_valid,
    input wire logic hash_accept
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_TX_LOW: assert property (tx_desc_base[1:0] == 2'h0)
        else $error("tx base low bits set");
    AST_RX_LOW: assert property (rx_desc_base[1:0] == 2'h0)
        else $error("rx base low bits set");
    AST_TX_UPD: assert property (tx_pkt_ok && !psel |=> tx_desc_base >> 2 == $past(tx_last_desc) >> 2)
        else $error("tx base not reloaded");
    AST_RX_UPD: assert property (rx_pkt_ok && !psel |=> rx_desc_base >> 2 == $past(rx_last_desc) >> 2)
        else $error("rx base not reloaded");
    AST_TX_DONE: assert property (tx_done && !psel |=> !transmit_request)
        else $error("request not cleared");
    AST_RX_GATE: assert property (hash_accept_valid |-> $past(rx_addr_valid, 2) && $past(receive_enable, 2)
        || $past(rx_addr_valid, 3) && $past(receive_enable, 3))
        else $error("verdict without enabled lookup");
    AST_HASH_EN: assert property (hash_accept_valid && hash_accept |-> hash_filter_enable)
        else $error("accept while filter off");
    AST_RESET: assert property ($rose(presetn) |-> !transmit_request && !receive_enable
        && tx_desc_base == 32'h0 && rx_desc_base == 32'h0)
        else $error("state not clear after reset");
    AST_ACK: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer late or long");
endmodule : edbhf_properties
bind edbhf_top edbhf_properties edbhf_properties_i
(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .tx_pkt_ok(tx_pkt_ok),
    .rx_pkt_ok(rx_pkt_ok),
    .tx_done(tx_done),
    .tx_last_desc(tx_last_desc),
    .rx_last_desc(rx_last_desc),
    .transmit_request(transmit_request),
    .receive_enable(receive_enable),
    .tx_desc_base(tx_desc_base),
    .rx_desc_base(rx_desc_base),
    .rx_addr_valid(rx_addr_valid),
    .hash_filter_enable(hash_filter_enable),
    .hash_accept_valid(hash_accept_valid),
    .hash_accept(hash_accept)
);
`default_nettype wire

// ---- test/edbhf_dma_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module edbhf_dma_model #(parameter int DLY = 3)
(
    // from the block
    input wire logic pclk,
    input wire logic transmit_request,
    input wire logic receive_enable,
    input wire logic [31:0] tx_desc_base,
    input wire logic [31:0] rx_desc_base,
    // completion reports
    output logic tx_pkt_ok = 1'h0,
    output logic tx_done = 1'h0,
    output logic rx_pkt_ok = 1'h0,
    output logic [31:0] tx_last_desc = 32'h0,
    output logic [31:0] rx_last_desc = 32'h0
);
    // tx walk: odd end offset so the block must drop bits 1:0
    always
    begin
        @(posedge pclk iff transmit_request);
        repeat (DLY) @(posedge pclk);
        tx_last_desc <= tx_desc_base + 32'h13;
        tx_pkt_ok <= 1'h1;
        @(posedge pclk);
        tx_pkt_ok <= 1'h0;
        tx_last_desc <= ~tx_last_desc;
        tx_done <= 1'h1;
        @(posedge pclk);
        tx_done <= 1'h0;
    end
    // rx walk: one packet each time receive turns on
    always
    begin
        @(posedge pclk iff receive_enable);
        repeat (DLY) @(posedge pclk);
        rx_last_desc <= rx_desc_base + 32'h22;
        rx_pkt_ok <= 1'h1;
        @(posedge pclk);
        rx_pkt_ok <= 1'h0;
        rx_last_desc <= ~rx_last_desc;
        wait (!receive_enable);
    end
endmodule : edbhf_dma_model
`default_nettype wire

// ---- test/tb_eth_descriptor_base_and_hash_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("Error %0t: mismatch", $time); end end
module tb_eth_descriptor_base_and_hash_filter;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rx_addr_valid = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, tx_last_desc, rx_last_desc, tx_desc_base, rx_desc_base, rd;
    logic [47:0] rx_dest_addr = 48'h0;
    logic pready, pslverr, tx_done, tx_pkt_ok, rx_pkt_ok, transmit_request, receive_enable, er;
    logic hash_filter_enable, hash_accept_valid, hash_accept;
    int err_total = 0, n_tests = 0;
    logic [7:0] ofs [6] = '{edbhf_pkg::TX_DESC_START_ADDR_OFS, edbhf_pkg::RX_DESC_START_ADDR_OFS,
        edbhf_pkg::HASH_FILTER_LOW_OFS, edbhf_pkg::HASH_FILTER_HIGH_OFS,
        edbhf_pkg::CONTROLLER_CONTROL_OFS, edbhf_pkg::RECEIVE_FILTER_CONFIG_OFS};
    edbhf_top edbhf_top_i
    (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .tx_done(tx_done),
        .tx_pkt_ok(tx_pkt_ok),
        .tx_last_desc(tx_last_desc),
        .transmit_request(transmit_request),
        .tx_desc_base(tx_desc_base),
        .rx_pkt_ok(rx_pkt_ok),
        .rx_last_desc(rx_last_desc),
        .receive_enable(receive_enable),
        .rx_desc_base(rx_desc_base),
        .rx_addr_valid(rx_addr_valid),
        .rx_dest_addr(rx_dest_addr),
        .hash_filter_enable(hash_filter_enable),
        .hash_accept_valid(hash_accept_valid),
        .hash_accept(hash_accept)
    );
    edbhf_dma_model edbhf_dma_model_i
    (
        .pclk(pclk),
        .transmit_request(transmit_request),
        .receive_enable(receive_enable),
        .tx_desc_base(tx_desc_base),
        .rx_desc_base(rx_desc_base),
        .tx_pkt_ok(tx_pkt_ok),
        .tx_done(tx_done),
        .rx_pkt_ok(rx_pkt_ok),
        .tx_last_desc(tx_last_desc),
        .rx_last_desc(rx_last_desc)
    );
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////
    // one apb transfer, plus an idle edge so psel is never set twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        for (int n = 0; n < 20 && pready !== 1'h1; n++) @(posedge pclk);
        if (pready !== 1'h1)
        begin
            err_total++;
            $display("Error %0t: apb answer missing", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        `CHK({er, rd}, {1'h0, e})
    endtask : rdchk
    // lookup; window of four edges covers the verdict latency
    task automatic look(input logic [47:0] a, input logic v, input logic e);
        logic [1:0] seen;
        seen = 2'h0;
        rx_addr_valid <= 1'h1;
        rx_dest_addr <= a;
        @(posedge pclk);
        rx_addr_valid <= 1'h0;
        repeat (4)
        begin
            @(posedge pclk);
            if (hash_accept_valid === 1'h1) seen = {1'h1, hash_accept};
        end
        `CHK(seen, {v, e})
    endtask : look
    ////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] ev [4] = '{32'hFFFF_FFFC, 32'hA5A5_A5A4, 32'h1234_567B, 32'h9ABC_DEF0};
        foreach (ofs[i]) rdchk(ofs[i], 32'h0);
        for (int i = 0; i < 4; i++) apb(1'h1, ofs[i], ev[i]);
        for (int i = 0; i < 4; i++) rdchk(ofs[i], ev[i]);
        `CHK({tx_desc_base, rx_desc_base}, {ev[0], ev[1]})
        apb(1'h0, 8'h1C, 32'h0);
        `CHK({er, rd}, {1'h1, 32'h0})
    endtask : t_regs
    // both paths at once; distinct end offsets expose a crossed base
    task automatic t_dma;
        apb(1'h1, ofs[0], 32'h100);
        apb(1'h1, ofs[1], 32'h200);
        apb(1'h1, ofs[4], 32'h300);
        for (int n = 0; n < 30 && (transmit_request || rx_desc_base !== 32'h220); n++) @(posedge pclk);
        rdchk(ofs[0], 32'h110);
        rdchk(ofs[1], 32'h220);
        rdchk(ofs[4], 32'h100);
        `CHK({transmit_request, receive_enable}, 2'h1)
    endtask : t_dma
    // hash edits made while filtering is still off
    task automatic t_hash;
        apb(1'h1, ofs[2], 32'h20);
        apb(1'h1, ofs[3], 32'h8000_0100);
        apb(1'h1, ofs[5], 32'h8000);
        rdchk(ofs[5], 32'h8000);
        `CHK(hash_filter_enable, 1'h1)
        look(48'h5, 1'h1, 1'h1);
        look(48'h6, 1'h1, 1'h0);
        look(48'h28, 1'h1, 1'h1);
        look(48'hFC0, 1'h1, 1'h1);
        rdchk(edbhf_pkg::STATUS_OFS, 32'h1);
        look(48'h8000_0000_0005, 1'h1, 1'h0);
        apb(1'h1, ofs[5], 32'h0);
        look(48'h5, 1'h1, 1'h0);
        apb(1'h1, ofs[4], 32'h0);
        look(48'h5, 1'h0, 1'h0);
    endtask : t_hash
    // mid-run reset must clear software and hardware written state alike
    task automatic t_rst;
        apb(1'h1, ofs[0], 32'h40);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (ofs[i]) rdchk(ofs[i], 32'h0);
        `CHK({tx_desc_base, rx_desc_base}, 64'h0)
    endtask : t_rst
    ////////////////////////////////////////
    task automatic close_out;
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_dma();
        t_hash();
        t_rst();
        close_out();
    end
    // watchdog well past the few hundred cycles the run needs
    initial
    begin
        #20000;
        err_total++;
        close_out();
    end
endmodule : tb_eth_descriptor_base_and_hash_filter
`default_nettype wire
